// ==== verilog/i2c_brg_pkg.sv ====
// Constants, field layouts and types shared by the baud generator and status logic
`default_nettype none
package i2c_brg_pkg;
    // Register bus shape
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFF_RELOAD = 3'h0;
    localparam logic [ADDR_W-1:0] OFF_BUFFER = 3'h1;
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 3'h2;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 3'h3;
    localparam logic [ADDR_W-1:0] OFF_REQUEST = 3'h4;

    // Control register fields
    localparam int CTL_ENABLE = 0;
    localparam int CTL_MASTER = 1;
    localparam int CTL_TENBIT = 2;
    localparam int CTL_ACKDATA = 3;
    localparam int CTL_W = 4;

    // Request register fields
    localparam int REQ_START = 0;
    localparam int REQ_RSTART = 1;
    localparam int REQ_STOP = 2;
    localparam int REQ_RECV = 3;
    localparam int REQ_ACK = 4;
    localparam int REQ_W = 5;

    // Reset values
    localparam logic [DATA_W-1:0] RELOAD_RST = 8'h00;
    localparam logic [DATA_W-1:0] BUFFER_RST = 8'h00;
    localparam logic [CTL_W-1:0] CONTROL_RST = 4'h0;
    localparam logic [REQ_W-1:0] REQUEST_RST = 5'h00;
    localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
    localparam logic [DATA_W-1:0] STATUS_WR_MASK = 8'hc0;

    // Oscillator cycles per baud counter decrement
    localparam int OSC_PER_TICK = 2;
    localparam logic [0:0] TICK_LAST = 1'(OSC_PER_TICK - 1);

    // Half periods of each kind of transfer
    localparam logic [4:0] HALVES_TX = 5'h12;
    localparam logic [4:0] HALVES_DATA = 5'h10;
    localparam logic [4:0] HALVES_RX = 5'h10;
    localparam logic [4:0] HALVES_ACK = 5'h02;

    // Status register layout, bit 7 first
    typedef struct packed {
        logic slewDisable;
        logic smbusLevels;
        logic dataNotAddr;
        logic stopSeen;
        logic startSeen;
        logic readWrite;
        logic addrUpdate;
        logic bufFull;
    } status_s;

    // Bus sequencer states
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_START_WAIT = 3'b001,
        SEQ_START_LOW = 3'b010,
        SEQ_XFER = 3'b011,
        SEQ_STOP_LOW = 3'b100,
        SEQ_STOP_HIGH = 3'b101,
        SEQ_RSTART_REL = 3'b110
    } seq_e;

    // Kinds of byte-level transfer
    typedef enum logic [1:0] {
        XF_TX = 2'b00,
        XF_RX = 2'b01,
        XF_ACK = 2'b10
    } xfer_e;
endpackage
`default_nettype wire

// ==== verilog/i2c_baud_gen_and_status.sv ====
// Serial port baud counter, bus sequencer and status register
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module i2c_baud_gen_and_status (
    input wire logic clk,
    input wire logic srst,
    input wire logic [i2c_brg_pkg::ADDR_W-1:0] regAddr,
    input wire logic [i2c_brg_pkg::DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [i2c_brg_pkg::DATA_W-1:0] regRdData,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic slaveByteDone,
    input wire logic slaveByteIsAddr,
    input wire logic slaveRwBit,
    input wire logic slaveNack,
    input wire logic tenBitUpdate,
    output logic portIdle,
    output logic slewControlDisable,
    output logic smbusLevels
);
    import i2c_brg_pkg::*;

    // Register decode helper
    function automatic logic regHit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off,
                                    input logic strobe);
        regHit = strobe && (addr == off);
    endfunction

    logic [DATA_W-1:0] reloadReg;
    logic [DATA_W-1:0] bufferReg;
    logic [CTL_W-1:0] controlReg;
    logic [REQ_W-1:0] requestReg;
    status_s statusReg;
    logic [DATA_W-1:0] rdDataReg;
    logic sclMeta, sclSync, sdaMeta, sdaSync, sdaPrev;
    logic tickReg;
    logic [DATA_W-1:0] baudCount;
    seq_e seqReg;
    xfer_e xferReg;
    logic [4:0] halfCnt;
    logic [DATA_W-1:0] shiftReg;
    logic sclOeReg, sdaOeReg;
    logic txBusy;
    logic firstByte;
    logic idleReg;

    // Decoded strobes and events
    logic portOn, masterOn, tenBitOn;
    logic wrReload, wrBuffer, wrControl, wrStatus, wrRequest, rdBuffer;
    logic startDet, stopDet, rollover, halfEnd, goingLow;
    logic [4:0] halfNext;
    logic xferDone, txDataDone, rxDone, txDone, acceptTx, acceptReq;
    logic [REQ_W-1:0] reqPick;

    assign portOn = controlReg[CTL_ENABLE];
    assign masterOn = controlReg[CTL_MASTER];
    assign tenBitOn = controlReg[CTL_TENBIT];
    assign wrReload = regHit(regAddr, OFF_RELOAD, regWrite);
    assign wrBuffer = regHit(regAddr, OFF_BUFFER, regWrite);
    assign wrControl = regHit(regAddr, OFF_CONTROL, regWrite);
    assign wrStatus = regHit(regAddr, OFF_STATUS, regWrite);
    assign wrRequest = regHit(regAddr, OFF_REQUEST, regWrite);
    assign rdBuffer = regHit(regAddr, OFF_BUFFER, regRead);

    // Start and Stop seen on the synchronised lines while the clock line is high
    assign startDet = sclSync && sdaPrev && !sdaSync;
    assign stopDet = sclSync && !sdaPrev && sdaSync;

    // Counter reaches zero on a decrement tick
    assign rollover = tickReg && (baudCount == 8'h00) && (seqReg != SEQ_IDLE);
    assign halfNext = halfCnt + 5'h01;
    assign halfEnd = rollover && (seqReg == SEQ_XFER);
    assign goingLow = halfEnd && !sclOeReg;
    assign xferDone = goingLow && (halfNext == ((xferReg == XF_TX) ? HALVES_TX :
                                                (xferReg == XF_RX) ? HALVES_RX : HALVES_ACK));
    assign txDataDone = goingLow && (xferReg == XF_TX) && (halfNext == HALVES_DATA);
    assign rxDone = xferDone && (xferReg == XF_RX);
    assign txDone = xferDone && (xferReg == XF_TX);

    // New work is taken only by an enabled, idle master
    assign acceptTx = wrBuffer && portOn && masterOn && (seqReg == SEQ_IDLE) && (requestReg == REQUEST_RST);
    assign acceptReq = wrRequest && portOn && masterOn && (seqReg == SEQ_IDLE) && (requestReg == REQUEST_RST)
                       && !acceptTx;

    // Highest priority request only: start, repeated start, stop, receive, ack
    always_comb begin
        reqPick = REQUEST_RST;
        if (regWrData[REQ_START]) begin
            reqPick[REQ_START] = 1'b1;
        end else if (regWrData[REQ_RSTART]) begin
            reqPick[REQ_RSTART] = 1'b1;
        end else if (regWrData[REQ_STOP]) begin
            reqPick[REQ_STOP] = 1'b1;
        end else if (regWrData[REQ_RECV]) begin
            reqPick[REQ_RECV] = 1'b1;
        end else if (regWrData[REQ_ACK]) begin
            reqPick[REQ_ACK] = 1'b1;
        end
    end

    // Two-stage synchronisers for the bus lines, plus a delayed copy for edges
    always_ff @(posedge clk) begin
        if (srst) begin
            sclMeta <= 1'b1;
            sclSync <= 1'b1;
            sdaMeta <= 1'b1;
            sdaSync <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclMeta <= sclIn;
            sclSync <= sclMeta;
            sdaMeta <= sdaIn;
            sdaSync <= sdaMeta;
            sdaPrev <= sdaSync;
        end
    end

    // Software registers: reload, control, buffer
    always_ff @(posedge clk) begin
        if (srst) begin
            reloadReg <= RELOAD_RST;
            controlReg <= CONTROL_RST;
            bufferReg <= BUFFER_RST;
        end else begin
            if (wrReload) begin
                reloadReg <= regWrData;
            end
            if (wrControl) begin
                controlReg <= regWrData[CTL_W-1:0];
            end
            if (rxDone) begin
                bufferReg <= {shiftReg[6:0], sdaSync};
            end else if (wrBuffer) begin
                bufferReg <= regWrData;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst || seqReg == SEQ_IDLE) begin
            tickReg <= 1'b0;
        end else begin
            tickReg <= (tickReg == TICK_LAST) ? 1'b0 : tickReg + 1'b1;
        end
    end

    // reload from register, once per half period, N+1 ticks per half
    always_ff @(posedge clk) begin
        if (srst) begin
            baudCount <= RELOAD_RST;
        end else if (acceptTx || acceptReq || rollover) begin
            baudCount <= reloadReg;
        end else if (seqReg == SEQ_START_WAIT && !sdaSync) begin
            // load held until data line is high
            baudCount <= reloadReg;
        end else if (tickReg == TICK_LAST && seqReg != SEQ_IDLE) begin
            baudCount <= baudCount - 8'h01;
        end
    end

    // Bus sequencer: start, repeated start, stop, byte and ack transfers
    always_ff @(posedge clk) begin
        if (srst || !portOn) begin
            seqReg <= SEQ_IDLE;
            xferReg <= XF_TX;
            halfCnt <= 5'h00;
            shiftReg <= 8'h00;
            sclOeReg <= 1'b0;
            sdaOeReg <= 1'b0;
        end else begin
            case (seqReg)
                SEQ_IDLE: begin
                    halfCnt <= 5'h00;
                    if (acceptTx) begin
                        seqReg <= SEQ_XFER;
                        xferReg <= XF_TX;
                        shiftReg <= regWrData;
                        sdaOeReg <= ~regWrData[7];
                    end else if (acceptReq) begin
                        if (reqPick[REQ_START]) begin
                            seqReg <= SEQ_START_WAIT;
                            sclOeReg <= 1'b0;
                            sdaOeReg <= 1'b0;
                        end else if (reqPick[REQ_RSTART]) begin
                            seqReg <= SEQ_RSTART_REL;
                            sdaOeReg <= 1'b0;
                        end else if (reqPick[REQ_STOP]) begin
                            seqReg <= SEQ_STOP_LOW;
                            sdaOeReg <= 1'b1;
                        end else if (reqPick[REQ_RECV]) begin
                            seqReg <= SEQ_XFER;
                            xferReg <= XF_RX;
                            sdaOeReg <= 1'b0;
                        end else begin
                            seqReg <= SEQ_XFER;
                            xferReg <= XF_ACK;
                            sdaOeReg <= ~controlReg[CTL_ACKDATA];
                        end
                    end
                end
                SEQ_RSTART_REL: begin
                    // Data released, then clock released for a fresh Start
                    if (rollover) begin
                        sclOeReg <= 1'b0;
                        seqReg <= SEQ_START_WAIT;
                    end
                end
                SEQ_START_WAIT: begin
                    // data line pulled low only after a full count with it high
                    if (rollover) begin
                        sdaOeReg <= 1'b1;
                        seqReg <= SEQ_START_LOW;
                    end
                end
                SEQ_START_LOW: begin
                    if (rollover) begin
                        sclOeReg <= 1'b1;
                        seqReg <= SEQ_IDLE;
                    end
                end
                SEQ_STOP_LOW: begin
                    if (rollover) begin
                        sclOeReg <= 1'b0;
                        seqReg <= SEQ_STOP_HIGH;
                    end
                end
                SEQ_STOP_HIGH: begin
                    if (rollover) begin
                        sdaOeReg <= 1'b0;
                        seqReg <= SEQ_IDLE;
                    end
                end
                SEQ_XFER: begin
                    // each rollover ends one half period
                    if (halfEnd) begin
                        halfCnt <= halfNext;
                        if (sclOeReg) begin
                            sclOeReg <= 1'b0;
                        end else begin
                            sclOeReg <= 1'b1;
                            shiftReg <= {shiftReg[6:0], sdaSync};
                            if (xferReg == XF_TX) begin
                                sdaOeReg <= (halfNext < HALVES_DATA) ? ~shiftReg[6] : 1'b0;
                            end else if (xferReg == XF_RX) begin
                                sdaOeReg <= 1'b0;
                            end
                            // stop with clock held low as last driven
                            if (xferDone) begin
                                seqReg <= SEQ_IDLE;
                            end
                        end
                    end
                end
                default: begin
                    seqReg <= SEQ_IDLE;
                end
            endcase
        end
    end

    // Request bits clear themselves when their sequence completes
    always_ff @(posedge clk) begin
        if (srst || !portOn) begin
            requestReg <= REQUEST_RST;
        end else if (acceptReq) begin
            requestReg <= reqPick;
        end else if ((seqReg == SEQ_START_LOW || seqReg == SEQ_STOP_HIGH) && rollover) begin
            requestReg <= REQUEST_RST;
        end else if (xferDone) begin
            requestReg <= REQUEST_RST;
        end
    end

    // Master transmit in progress and first-byte tracking
    always_ff @(posedge clk) begin
        if (srst || !portOn) begin
            txBusy <= 1'b0;
            firstByte <= 1'b0;
        end else begin
            if (acceptTx) begin
                txBusy <= 1'b1;
            end else if (txDone) begin
                txBusy <= 1'b0;
            end
            if (startDet) begin
                firstByte <= 1'b1;
            end else if (txDone || rxDone || (slaveByteDone && !masterOn)) begin
                firstByte <= 1'b0;
            end
        end
    end

    // idle when no transmit and no request pending
    always_ff @(posedge clk) begin
        if (srst) begin
            idleReg <= 1'b1;
        end else begin
            idleReg <= !(txBusy || acceptTx || (requestReg != REQUEST_RST) || acceptReq);
        end
    end

    // writable upper bits, slew select, threshold select
    always_ff @(posedge clk) begin
        if (srst) begin
            statusReg.slewDisable <= STATUS_RST[7];
            statusReg.smbusLevels <= STATUS_RST[6];
        end else if (wrStatus) begin
            statusReg.slewDisable <= regWrData[7];
            statusReg.smbusLevels <= regWrData[6];
        end
    end

    // data or address of the last byte
    always_ff @(posedge clk) begin
        if (srst) begin
            statusReg.dataNotAddr <= STATUS_RST[5];
        end else if (masterOn && (txDone || rxDone)) begin
            statusReg.dataNotAddr <= !firstByte;
        end else if (!masterOn && slaveByteDone) begin
            statusReg.dataNotAddr <= !slaveByteIsAddr;
        end
    end

    // stop seen last, start seen last, both cleared on disable
    always_ff @(posedge clk) begin
        if (srst || !portOn) begin
            statusReg.stopSeen <= STATUS_RST[4];
            statusReg.startSeen <= STATUS_RST[3];
        end else if (startDet) begin
            statusReg.startSeen <= 1'b1;
            statusReg.stopSeen <= 1'b0;
        end else if (stopDet) begin
            statusReg.stopSeen <= 1'b1;
            statusReg.startSeen <= 1'b0;
        end
    end

    // transmit in progress in master mode, matched read/write bit in slave mode
    always_ff @(posedge clk) begin
        if (srst) begin
            statusReg.readWrite <= STATUS_RST[2];
        end else if (masterOn) begin
            statusReg.readWrite <= txBusy;
        end else if (slaveByteDone && slaveByteIsAddr) begin
            statusReg.readWrite <= slaveRwBit;
        end else if (startDet || stopDet || slaveNack) begin
            statusReg.readWrite <= 1'b0;
        end
    end

    // address update request, ten-bit mode only; cleared by reload write
    always_ff @(posedge clk) begin
        if (srst) begin
            statusReg.addrUpdate <= STATUS_RST[1];
        end else if (tenBitOn && tenBitUpdate) begin
            statusReg.addrUpdate <= 1'b1;
        end else if (wrReload || !tenBitOn) begin
            statusReg.addrUpdate <= 1'b0;
        end
    end

    // set on full receive, held over transmit data bits; set beats clear
    always_ff @(posedge clk) begin
        if (srst || !portOn) begin
            statusReg.bufFull <= STATUS_RST[0];
        end else if (rxDone || acceptTx || (!masterOn && slaveByteDone)) begin
            statusReg.bufFull <= 1'b1;
        end else if (txDataDone || rdBuffer) begin
            statusReg.bufFull <= 1'b0;
        end
    end

    // Read data, valid the cycle after the read strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (srst) begin
            rdDataReg <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                OFF_RELOAD: rdDataReg <= reloadReg;
                OFF_BUFFER: rdDataReg <= bufferReg;
                OFF_CONTROL: rdDataReg <= {{(DATA_W-CTL_W){1'b0}}, controlReg};
                OFF_STATUS: rdDataReg <= statusReg;
                OFF_REQUEST: rdDataReg <= {{(DATA_W-REQ_W){1'b0}}, requestReg};
                default: rdDataReg <= 8'h00;
            endcase
        end else begin
            rdDataReg <= 8'h00;
        end
    end

    // Output pins: open drain, low level driven while the enable is high
    always_ff @(posedge clk) begin
        if (srst) begin
            sclOut <= 1'b0;
            sdaOut <= 1'b0;
        end else begin
            sclOut <= 1'b0;
            sdaOut <= 1'b0;
        end
    end

    assign sclOe = sclOeReg;
    assign sdaOe = sdaOeReg;
    assign regRdData = rdDataReg;
    assign portIdle = idleReg;
    assign slewControlDisable = statusReg.slewDisable;
    assign smbusLevels = statusReg.smbusLevels;
endmodule // i2c_baud_gen_and_status
`default_nettype wire

// ==== verif/i2c_bus_partner.sv ====
// Bus pull-ups and a far-side device that watches the lines and disturbs the data line
`timescale 1ns/10ps
`default_nettype none
module i2c_bus_partner (
    input wire logic clk,
    input wire logic sclOe,
    input wire logic sdaOe,
    output logic sclLine,
    output logic sdaLine,
    output logic [7:0] rxByte,
    output logic [7:0] pulses
);
    logic sdaPull = 1'b0;
    // Open-drain lines with pull-ups, released lines read high
    assign sclLine = !sclOe;
    assign sdaLine = !(sdaOe || sdaPull);
    initial pulses = 8'h00;
    // Shift the data line in at each clock rise, MSB first
    always @(posedge sclLine) begin
        rxByte <= {rxByte[6:0], sdaLine};
        pulses <= pulses + 8'h01;
    end
    // Pull or release the data line while the clock is high, then dwell
    task automatic drive(input logic v);
        @(posedge clk);
        sdaPull <= v;
        repeat (20) @(posedge clk);
    endtask
endmodule // i2c_bus_partner
`default_nettype wire

// ==== verif/i2c_baud_gen_and_status_properties.sv ====
// Assertions on the baud generator and status ports
`timescale 1ns/10ps
`default_nettype none
module i2c_baud_gen_and_status_properties (
    input wire logic clk,
    input wire logic srst,
    input wire logic [i2c_brg_pkg::ADDR_W-1:0] regAddr,
    input wire logic [i2c_brg_pkg::DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [i2c_brg_pkg::DATA_W-1:0] regRdData,
    input wire logic sclOe,
    input wire logic sdaOe,
    input wire logic portIdle,
    input wire logic slewControlDisable,
    input wire logic smbusLevels
);
    import i2c_brg_pkg::*;
    logic [7:0] reloadCopy;
    logic [9:0] gapCnt;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Reload shadow and saturating cycles since the clock enable moved
    always_ff @(posedge clk) begin
        if (srst) begin
            reloadCopy <= RELOAD_RST;
            gapCnt <= 10'h3ff;
        end else begin
            if (regWrite && regAddr == OFF_RELOAD) begin
                reloadCopy <= regWrData;
            end
            gapCnt <= $changed(sclOe) ? 10'h000 : gapCnt + 10'(gapCnt != 10'h3ff);
        end
    end
    AST_RD_QUIET:
        assert property (!$past(regRead) |-> regRdData == 8'h00) else $error("read data outside read cycle");
    AST_RD_TOP:
        assert property ($past(regRead) && $past(regAddr) == OFF_STATUS |-> regRdData[7:6] ==
            {$past(slewControlDisable), $past(smbusLevels)}) else $error("status top bits differ");
    AST_SLEW:
        assert property ($past(regWrite) && $past(regAddr) == OFF_STATUS |->
            slewControlDisable == $past(regWrData[7])) else $error("slew output not written");
    AST_SMBUS:
        assert property ($past(regWrite) && $past(regAddr) == OFF_STATUS |->
            smbusLevels == $past(regWrData[6])) else $error("threshold output not written");
    AST_RESET:
        assert property ($fell(srst) |-> !sclOe && !sdaOe && portIdle && regRdData == 8'h00)
            else $error("outputs wrong after reset");
    AST_HALF_MIN:
        assert property ($changed(sclOe) |-> gapCnt >= {1'b0, reloadCopy, 1'b0})
            else $error("clock half period too short");
    AST_START_HOLD:
        assert property ($rose(sdaOe) && !sclOe |=> !sclOe [*6]) else $error("clock pulled early in start");
    AST_IDLE_STILL:
        assert property (portIdle && $past(portIdle) && !$past(regWrite) && !$past(regWrite, 2) |->
            $stable(sclOe) && $stable(sdaOe)) else $error("lines moved while idle");
endmodule // i2c_baud_gen_and_status_properties
bind i2c_baud_gen_and_status i2c_baud_gen_and_status_properties u_i2c_baud_gen_and_status_properties (
    .clk, .srst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .sclOe, .sdaOe, .portIdle,
    .slewControlDisable, .smbusLevels
);
`default_nettype wire

// ==== verif/i2c_baud_gen_and_status_test.sv ====
// Self-checking bench for the baud generator and status block
`timescale 1ns/10ps
`default_nettype none
module i2c_baud_gen_and_status_test;
    import i2c_brg_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWrData = '0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [4:0] slv = 5'h00;
    logic [DATA_W-1:0] regRdData;
    logic sclOe, sdaOe, sclLine, sdaLine, portIdle, slewControlDisable, smbusLevels;
    logic [7:0] rxByte, pulses, d, p0;
    logic [7:0] rl [3] = '{8'h04, 8'h0b, 8'h13};
    int fails = 0;
    int checksDone = 0;
    time t0;
    // Clock at 25 ns
    initial forever #12.5 clk = !clk;
    i2c_baud_gen_and_status u_i2c_baud_gen_and_status (
        .clk, .srst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
        .sclIn(sclLine), .sclOut(), .sclOe, .sdaIn(sdaLine), .sdaOut(), .sdaOe,
        .slaveByteDone(slv[4]), .slaveByteIsAddr(slv[3]), .slaveRwBit(slv[2]),
        .slaveNack(slv[1]), .tenBitUpdate(slv[0]), .portIdle, .slewControlDisable, .smbusLevels
    );
    i2c_bus_partner u_i2c_bus_partner (.clk, .sclOe, .sdaOe, .sclLine, .sdaLine, .rxByte, .pulses);
    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One-cycle register write
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
        @(posedge clk);
        regAddr <= a;
        regWrData <= v;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    // Register read, data taken in the cycle after the strobe, masked
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        chk(regRdData & m, e);
    endtask
    // Slave-side event pulse, keeping the level qualifiers
    task automatic pulse(input logic [4:0] v);
        @(posedge clk);
        slv <= v;
        @(posedge clk);
        slv <= v & 5'h0c;
    endtask
    // Busy shortly after a request, then bounded wait for idle
    task automatic waitIdle();
        repeat (3) @(negedge clk);
        chk({7'h0, portIdle}, 8'h00);
        for (int i = 0; i < 4000 && portIdle !== 1'b1; i++) @(negedge clk);
        chk({7'h0, portIdle}, 8'h01);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        #(25 * 30000);
        fails++;
        print_verdict();
    end
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd(OFF_STATUS, 8'hff, 8'h00);
        wr(OFF_RELOAD, 8'h5a);
        rd(OFF_RELOAD, 8'hff, 8'h5a);
        wr(OFF_STATUS, 8'hff);
        rd(OFF_STATUS, 8'hff, 8'hc0);
        wr(OFF_STATUS, 8'h80);
        rd(OFF_STATUS, 8'hff, 8'h80);
        chk({6'h0, slewControlDisable, smbusLevels}, 8'h02);
        wr(OFF_STATUS, 8'h00);
        rd(3'h7, 8'hff, 8'h00);
        $display("register test done");
        wr(OFF_CONTROL, 8'h01);
        u_i2c_bus_partner.drive(1'b1);
        rd(OFF_STATUS, 8'hff, 8'h08);
        u_i2c_bus_partner.drive(1'b0);
        rd(OFF_STATUS, 8'hff, 8'h10);
        u_i2c_bus_partner.drive(1'b1);
        wr(OFF_CONTROL, 8'h00);
        rd(OFF_STATUS, 8'hff, 8'h00);
        u_i2c_bus_partner.drive(1'b0);
        $display("bus event test done");
        wr(OFF_CONTROL, 8'h05);
        pulse(5'h1c);
        rd(OFF_STATUS, 8'h27, 8'h05);
        pulse(5'h01);
        rd(OFF_STATUS, 8'h27, 8'h07);
        pulse(5'h10);
        rd(OFF_STATUS, 8'h27, 8'h27);
        pulse(5'h02);
        rd(OFF_STATUS, 8'h27, 8'h23);
        wr(OFF_RELOAD, 8'h04);
        wr(OFF_CONTROL, 8'h01);
        pulse(5'h01);
        rd(OFF_STATUS, 8'h27, 8'h21);
        $display("slave test done");
        // Master transfers at each tabled reload value
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        wr(OFF_CONTROL, 8'h03);
        for (int k = 0; k < 3; k++) begin
            wr(OFF_RELOAD, rl[k]);
            wr(OFF_REQUEST, 8'h01);
            waitIdle();
            rd(OFF_STATUS, 8'h18, 8'h08);
            p0 = pulses;
            wr(OFF_BUFFER, 8'ha5);
            rd(OFF_STATUS, 8'h1f, 8'h0d);
            @(posedge sclLine);
            t0 = $time;
            @(posedge sclLine);
            d = 8'(($time - t0) / 25);
            chk({7'h0, d >= 4 * rl[k] + 4 && d <= 4 * rl[k] + 12}, 8'h01);
            waitIdle();
            chk(pulses - p0, 8'h09);
            chk(rxByte, 8'h4b);
            rd(OFF_STATUS, 8'h3f, 8'h08);
            repeat (40) @(posedge clk);
            chk({7'h0, sclLine}, 8'h00);
            wr(OFF_REQUEST, 8'h08);
            waitIdle();
            rd(OFF_STATUS, 8'h3f, 8'h29);
            rd(OFF_BUFFER, 8'hff, 8'hff);
            wr(OFF_REQUEST, 8'h04);
            waitIdle();
            // Stop is seen through the synchronisers a few cycles after idle
            repeat (4) @(posedge clk);
            rd(OFF_STATUS, 8'h18, 8'h10);
            chk({6'h0, sclLine, sdaLine}, 8'h03);
        end
        $display("master test done");
        print_verdict();
    end
endmodule // i2c_baud_gen_and_status_test
`default_nettype wire
